// *** hdl/tsc_cm_access.sv ***
// What this block does
// - Tristate command to PCM timeslot stores low data nibble as output enables.
// - Tristate command with low nibble zero makes whole timeslot high impedance.
// - Read-data command returns stored PCM pointer in the data register.
// - Read-code command returns 4-bit code in data register low bits.
// - Busy flag stays set while a command is pending; host polls it.
// - Cancel command writes code zero and ignores the data register.
// - Code 0001 switches a full 8-bit channel.
// - Connection stored at line named by address, data register is pointer.
// - Code field selects switched width and PCM bit position.
// - Line-card bit position comes from the per-port 2-bit mode.
// - Subchannel select register: 8 bits, RW, reset zero, 2 bits per port.
// - One sub-timeslot per line-card timeslot; PCM timeslots may mix.
// - Code 0100 uses PCM bits 1:0, code 0110 uses PCM bits 5:4.
// - Port mode 11 puts a 2-bit connection on line-card bits 1:0.
// - Only codes with MSB zero mark a switched channel.
// - Data-only write updates the pointer and keeps the code.
`timescale 1ns/1ps
`default_nettype none
`include "tsc_defs.svh"

module tsc_cm_access
    import tsc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Connection lookup from the switching datapath
    input wire logic [7:0] lookup_slot,
    output tsc_conn_t lookup_conn,
    // Output enable lookup for a PCM transmit timeslot
    input wire logic [6:0] tx_slot,
    output logic [3:0] tx_enable
);

    // ========================================================
    // Storage
    // Each control memory line is one line-card timeslot.
    logic [7:0] mem_ptr [0:255];
    logic [3:0] mem_code [0:255];
    logic [3:0] tri_field [0:127];

    // ========================================================
    // Register file and command sequencer state
    logic [7:0] data_reg;
    logic [7:0] addr_reg;
    logic [7:0] cmd_reg;
    logic [7:0] subch_sel;
    logic busy;
    tsc_state_t state;
    logic [1:0] wait_cnt;
    logic [7:0] read_buf;
    logic [7:0] next_data_reg;
    logic [7:0] next_addr_reg;
    logic [7:0] next_cmd_reg;
    logic [7:0] next_subch_sel;
    logic next_busy;
    tsc_state_t next_state;
    logic [1:0] next_wait_cnt;
    logic [7:0] next_read_buf;
    logic [7:0] next_reg_rdata;

    // Memory write controls
    logic mem_ptr_we;
    logic mem_code_we;
    logic tri_we;
    logic [7:0] mem_ptr_wval;
    logic [3:0] mem_code_wval;

    logic cmd_write;
    logic is_code_write;

    assign cmd_write = reg_wr && (reg_addr == `TSC_OFS_CMD);
    assign is_code_write = (cmd_reg[7:4] == `TSC_CMD_CODE_HI);

    // ========================================================
    // Register port
    always_comb
    begin
        next_data_reg = data_reg;
        next_addr_reg = addr_reg;
        next_cmd_reg = cmd_reg;
        next_subch_sel = subch_sel;
        next_reg_rdata = `TSC_REG_RESET;
        if (reg_wr)
        begin
            case (reg_addr)
                `TSC_OFS_DATA:
                    next_data_reg = reg_wdata;
                `TSC_OFS_ADDR:
                    next_addr_reg = reg_wdata;
                `TSC_OFS_CMD:
                    // A command issued while busy is dropped
                    if (!busy)
                    begin
                        next_cmd_reg = reg_wdata;
                    end
                `TSC_OFS_SUBCH:
                    next_subch_sel = reg_wdata;
                default:
                    next_subch_sel = subch_sel;
            endcase
        end
        if (reg_rd)
        begin
            case (reg_addr)
                `TSC_OFS_DATA:
                    next_reg_rdata = data_reg;
                `TSC_OFS_ADDR:
                    next_reg_rdata = addr_reg;
                `TSC_OFS_CMD:
                    next_reg_rdata = cmd_reg;
                `TSC_OFS_STATUS:
                    next_reg_rdata[`TSC_STATUS_BUSY_BIT] = busy;
                `TSC_OFS_SUBCH:
                    next_reg_rdata = subch_sel;
                default:
                    next_reg_rdata = `TSC_REG_RESET;
            endcase
        end
        // Read-back result lands in the data register
        if (state == TSC_LOAD)
        begin
            next_data_reg = read_buf;
        end
    end

    // ========================================================
    // Command sequencer
    always_comb
    begin
        next_state = state;
        next_busy = busy;
        next_wait_cnt = wait_cnt;
        next_read_buf = read_buf;
        mem_ptr_we = 1'b0;
        mem_code_we = 1'b0;
        tri_we = 1'b0;
        mem_ptr_wval = data_reg;
        mem_code_wval = cmd_reg[3:0];
        case (state)
            TSC_IDLE:
                if (cmd_write)
                begin
                    next_busy = 1'b1;
                    next_wait_cnt = `TSC_CMD_WAIT;
                    next_state = TSC_WAIT;
                end
            TSC_WAIT:
                if (wait_cnt == 2'h0)
                begin
                    next_state = TSC_EXEC;
                end
                else
                begin
                    next_wait_cnt = wait_cnt - 2'h1;
                end
            TSC_EXEC:
            begin
                next_state = TSC_IDLE;
                next_busy = 1'b0;
                if (cmd_reg == `TSC_CMD_TRISTATE)
                begin
                    tri_we = 1'b1;
                end
                else if (cmd_reg == `TSC_CMD_DATA_ONLY)
                begin
                    mem_ptr_we = 1'b1;
                end
                else if (cmd_reg == `TSC_CMD_READ_DATA)
                begin
                    next_read_buf = mem_ptr[addr_reg];
                    next_busy = 1'b1;
                    next_state = TSC_LOAD;
                end
                else if (cmd_reg == `TSC_CMD_READ_CODE)
                begin
                    // Upper bits are left at zero
                    next_read_buf = {4'h0, mem_code[addr_reg]};
                    next_busy = 1'b1;
                    next_state = TSC_LOAD;
                end
                else if (is_code_write)
                begin
                    mem_code_we = 1'b1;
                    if (cmd_reg[3:0] == `TSC_CODE_UNASSIGNED)
                    begin
                        // Cancel keeps the old pointer
                        mem_code_wval = `TSC_CODE_UNASSIGNED;
                    end
                    else
                    begin
                        mem_ptr_we = 1'b1;
                    end
                end
            end
            TSC_LOAD:
            begin
                // Busy drops only once the data register holds the result
                next_busy = 1'b0;
                next_state = TSC_IDLE;
            end
            default:
            begin
                next_state = TSC_IDLE;
                next_busy = 1'b0;
            end
        endcase
    end

    // ========================================================
    // Connection decode
    // Each line carries one sub-timeslot; PCM masks of different
    // lines may share one PCM timeslot.
    logic [7:0] lk_ptr;
    logic [3:0] lk_code;
    logic [1:0] lk_mode;
    tsc_conn_t next_conn;

    assign lk_ptr = mem_ptr[lookup_slot];
    assign lk_code = mem_code[lookup_slot];

    always_comb
    begin
        lk_mode = subch_sel[1:0];
        for (int p = 0; p < 4; p++)
        begin
            if (lookup_slot[1:0] == p[1:0])
            begin
                lk_mode = subch_sel[2*p +: 2];
            end
        end
        next_conn.pointer = lk_ptr;
        next_conn.code = lk_code;
        next_conn.switched = !lk_code[3] &&
            (lk_code != `TSC_CODE_UNASSIGNED);
        case (lk_code)
            4'h1: next_conn.pcm_mask = 8'hff;
            4'h3: next_conn.pcm_mask = 8'hf0;
            4'h2: next_conn.pcm_mask = 8'h0f;
            4'h7: next_conn.pcm_mask = 8'hc0;
            4'h6: next_conn.pcm_mask = 8'h30;
            4'h5: next_conn.pcm_mask = 8'h0c;
            4'h4: next_conn.pcm_mask = 8'h03;
            default: next_conn.pcm_mask = 8'h00;
        endcase
        case (lk_code)
            4'h1:
                next_conn.lc_mask = 8'hff;
            4'h2, 4'h3:
                next_conn.lc_mask = lk_mode[0] ? 8'h0f : 8'hf0;
            4'h4, 4'h5, 4'h6, 4'h7:
            begin
                case (lk_mode)
                    2'b00: next_conn.lc_mask = 8'hc0;
                    2'b01: next_conn.lc_mask = 8'h30;
                    2'b10: next_conn.lc_mask = 8'h0c;
                    2'b11: next_conn.lc_mask = 8'h03;
                    default: next_conn.lc_mask = 8'h00;
                endcase
            end
            default:
                next_conn.lc_mask = 8'h00;
        endcase
        if (!next_conn.switched)
        begin
            next_conn.pcm_mask = 8'h00;
            next_conn.lc_mask = 8'h00;
        end
    end

    // ========================================================
    // Registers
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            data_reg <= `TSC_REG_RESET;
            addr_reg <= `TSC_REG_RESET;
            cmd_reg <= `TSC_REG_RESET;
            subch_sel <= `TSC_SUBCH_RESET;
            busy <= 1'b0;
            state <= TSC_IDLE;
            wait_cnt <= 2'h0;
            read_buf <= `TSC_REG_RESET;
            reg_rdata <= `TSC_REG_RESET;
            lookup_conn <= '0;
            tx_enable <= `TSC_TRI_ALL_OFF;
        end
        else
        begin
            data_reg <= next_data_reg;
            addr_reg <= next_addr_reg;
            cmd_reg <= next_cmd_reg;
            subch_sel <= next_subch_sel;
            busy <= next_busy;
            state <= next_state;
            wait_cnt <= next_wait_cnt;
            read_buf <= next_read_buf;
            reg_rdata <= next_reg_rdata;
            lookup_conn <= next_conn;
            tx_enable <= tri_field[tx_slot];
        end
    end

    // Pointer and code memories carry no reset; software programs every line in use.
    // Tristate entries start all off so no driver fights the bus.
    logic tri_init;
    logic [6:0] tri_init_idx;
    logic next_tri_init;
    logic [6:0] next_tri_init_idx;

    always_comb
    begin
        next_tri_init = tri_init;
        next_tri_init_idx = tri_init_idx;
        if (tri_init)
        begin
            next_tri_init_idx = tri_init_idx + 7'h1;
            if (tri_init_idx == 7'h7f)
            begin
                next_tri_init = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            tri_init <= 1'b1;
            tri_init_idx <= 7'h00;
        end
        else
        begin
            tri_init <= next_tri_init;
            tri_init_idx <= next_tri_init_idx;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (mem_ptr_we)
        begin
            mem_ptr[addr_reg] <= mem_ptr_wval;
        end
        if (mem_code_we)
        begin
            mem_code[addr_reg] <= mem_code_wval;
        end
        if (tri_init)
        begin
            tri_field[tri_init_idx] <= `TSC_TRI_ALL_OFF;
        end
        else if (tri_we)
        begin
            tri_field[addr_reg[6:0]] <= data_reg[3:0];
        end
    end

endmodule // tsc_cm_access

`default_nettype wire

// *** hdl/tsc_defs.svh ***
`ifndef TSC_DEFS_SVH
`define TSC_DEFS_SVH

// Register offsets on the plain register port
`define TSC_OFS_DATA 3'h0
`define TSC_OFS_ADDR 3'h1
`define TSC_OFS_CMD 3'h2
`define TSC_OFS_STATUS 3'h3
`define TSC_OFS_SUBCH 3'h4

// Reset values
`define TSC_SUBCH_RESET 8'h00
`define TSC_REG_RESET 8'h00

// Status register fields
`define TSC_STATUS_BUSY_BIT 0

// Command codes
`define TSC_CMD_TRISTATE 8'h60
`define TSC_CMD_DATA_ONLY 8'h48
`define TSC_CMD_READ_DATA 8'hc8
`define TSC_CMD_READ_CODE 8'hf0
`define TSC_CMD_CODE_HI 4'h7

// Connection codes
`define TSC_CODE_UNASSIGNED 4'h0
`define TSC_CODE_FULL 4'h1
`define TSC_TRI_ALL_ON 4'hf
`define TSC_TRI_ALL_OFF 4'h0

// Wait count loaded at the command write; the memory access comes 4 cycles after the write
`define TSC_CMD_WAIT 2'h2

`endif

// *** hdl/tsc_pkg.sv ***
package tsc_pkg;

    typedef enum logic [1:0]
    {
        TSC_IDLE = 2'b00,
        TSC_WAIT = 2'b01,
        TSC_EXEC = 2'b10,
        TSC_LOAD = 2'b11
    } tsc_state_t;

    typedef struct packed
    {
        logic [7:0] pointer;
        logic [3:0] code;
        logic switched;
        logic [7:0] pcm_mask;
        logic [7:0] lc_mask;
    } tsc_conn_t;

endpackage

// *** tb/tsc_cm_access_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tsc_defs.svh"
// ==========
// Checker on the ports of tsc_cm_access
module tsc_cm_access_properties
    import tsc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Lookups
    input wire logic [7:0] lookup_slot,
    input wire tsc_conn_t lookup_conn,
    input wire logic [6:0] tx_slot,
    input wire logic [3:0] tx_enable
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not cleared");
    status_bits_a: assert property (reg_rd &&
        reg_addr == `TSC_OFS_STATUS |=> reg_rdata[7:1] == 7'h00)
        else $error("status spare bits set");
    subch_echo_a: assert property (reg_wr &&
        reg_addr == `TSC_OFS_SUBCH ##1 !reg_wr ##1 reg_rd &&
        reg_addr == `TSC_OFS_SUBCH |=> reg_rdata == $past(reg_wdata, 3))
        else $error("subch readback");
    mask_off_a: assert property (!lookup_conn.switched |->
        lookup_conn.pcm_mask == 8'h00 && lookup_conn.lc_mask == 8'h00)
        else $error("masks set on idle line");
    switch_code_a: assert property (lookup_conn.switched |->
        !lookup_conn.code[3] && lookup_conn.code != 4'h0)
        else $error("switched with bad code");
    full_chan_a: assert property (lookup_conn.switched &&
        lookup_conn.code == `TSC_CODE_FULL |-> lookup_conn.pcm_mask == 8'hff
        && lookup_conn.lc_mask == 8'hff) else $error("full channel masks");
    low_quarter_a: assert property (lookup_conn.switched &&
        lookup_conn.code == 4'h4 |-> lookup_conn.pcm_mask == 8'h03)
        else $error("code 4 mask");
    mid_quarter_a: assert property (lookup_conn.switched &&
        lookup_conn.code == 4'h6 |-> lookup_conn.pcm_mask == 8'h30)
        else $error("code 6 mask");
    same_width_a: assert property (lookup_conn.switched |->
        $countones(lookup_conn.lc_mask) == $countones(lookup_conn.pcm_mask))
        else $error("side widths differ");

    cover property (reg_wr && reg_addr == `TSC_OFS_CMD);
    cover property (reg_rd && reg_addr == `TSC_OFS_STATUS ##1 reg_rdata[0]);
    cover property (lookup_conn.switched && lookup_conn.code == 4'h4);
endmodule // tsc_cm_access_properties
`default_nettype wire

// *** tb/tsc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tsc_defs.svh"
// ==========
// Host processor on the register port
module tsc_host_model
(
    // Clock
    input wire logic ref_clk,
    // Register port
    output logic [2:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    initial
    begin
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        // Released data must not look like the last value
        reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        d = reg_rdata;
    endtask

    // Returns {busy at first poll, busy at last poll}
    task automatic cmd(input logic [7:0] a, input logic [7:0] d,
        input logic [7:0] c, output logic [1:0] bs);
        logic [7:0] s;
        int n;
        wr(`TSC_OFS_DATA, d);
        wr(`TSC_OFS_ADDR, a);
        wr(`TSC_OFS_CMD, c);
        rd(`TSC_OFS_STATUS, s);
        bs[1] = s[0];
        n = 0;
        // No new command until the access is over
        while (s[0] !== 1'b0 && n < 20)
        begin
            rd(`TSC_OFS_STATUS, s);
            n++;
        end
        bs[0] = s[0];
    endtask
endmodule // tsc_host_model
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tsc_defs.svh"
module testbench
    import tsc_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic [7:0] lookup_slot;
    tsc_conn_t lookup_conn;
    logic [6:0] tx_slot;
    logic [3:0] tx_enable;
    int failures = 0;
    int compares = 0;
    int cycles = 0;
    logic [31:0] seed = 32'd95;
    logic [3:0] nib [3] = '{4'hf, 4'h5, 4'h0};

    tsc_cm_access u_tsc_cm_access (.ref_clk(ref_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lookup_slot(lookup_slot),
        .lookup_conn(lookup_conn), .tx_slot(tx_slot), .tx_enable(tx_enable));
    tsc_host_model u_tsc_host_model (.ref_clk(ref_clk),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    always #20 ref_clk = ~ref_clk;

    // ==========
    // Hang guard, far above the fewer than one thousand cycles the tests need
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            failures++;
            give_verdict();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [7:0] pcm_exp(input logic [3:0] c);
        case (c)
            4'h1: return 8'hff;
            4'h2: return 8'h0f;
            4'h3: return 8'hf0;
            4'h4: return 8'h03;
            4'h5: return 8'h0c;
            4'h6: return 8'h30;
            4'h7: return 8'hc0;
            default: return 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] lc_exp(input logic [1:0] m,
        input logic [3:0] c);
        if (c == 4'h1)
            return 8'hff;
        if (c == 4'h2 || c == 4'h3)
            return m[0] ? 8'h0f : 8'hf0;
        if (c[3:2] == 2'b01)
            return 8'hc0 >> (2 * m);
        return 8'h00;
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic look(input logic [7:0] a, output tsc_conn_t q,
        output logic [3:0] te);
        @(posedge ref_clk);
        lookup_slot <= a;
        tx_slot <= a[6:0];
        @(posedge ref_clk);
        @(negedge ref_clk);
        q = lookup_conn;
        te = tx_enable;
    endtask

    task automatic give_verdict();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ==========
    // Main sequence
    initial
    begin
        logic [7:0] a, d, m, r;
        logic [1:0] bs;
        logic [3:0] te;
        tsc_conn_t q;
        rst = 1'b1;
        lookup_slot = 8'h00;
        tx_slot = 7'h00;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        u_tsc_host_model.rd(`TSC_OFS_SUBCH, r);
        chk(r, `TSC_SUBCH_RESET);
        u_tsc_host_model.rd(3'h6, r);
        chk(r, 8'h00);
        $display("test reset finished");
        // Codes 1 to 9, with a random port mode behind each slot
        for (int c = 1; c < 10; c++)
        begin
            a = 8'(rnd());
            d = 8'(rnd());
            m = 8'(rnd());
            u_tsc_host_model.wr(`TSC_OFS_SUBCH, m);
            u_tsc_host_model.rd(`TSC_OFS_SUBCH, r);
            chk(r, m);
            u_tsc_host_model.cmd(a, d, {4'h7, c[3:0]}, bs);
            chk({6'h0, bs}, 8'h02);
            look(a, q, te);
            chk(q.pointer, d);
            chk({4'h0, q.code}, {4'h0, c[3:0]});
            chk({7'h0, q.switched}, {7'h0, c < 8});
            chk(q.pcm_mask, pcm_exp(c[3:0]));
            chk(q.lc_mask, lc_exp(m[2*a[1:0] +: 2], c[3:0]));
            u_tsc_host_model.cmd(a, ~d, `TSC_CMD_READ_DATA, bs);
            chk({6'h0, bs}, 8'h02);
            u_tsc_host_model.rd(`TSC_OFS_DATA, r);
            chk(r, d);
            u_tsc_host_model.cmd(a, d, `TSC_CMD_READ_CODE, bs);
            u_tsc_host_model.rd(`TSC_OFS_DATA, r);
            chk(r, {4'h0, c[3:0]});
        end
        $display("test codes finished");
        // Pointer-only update, then cancel with junk data
        a = 8'(rnd());
        d = 8'(rnd());
        u_tsc_host_model.cmd(a, 8'(rnd()), 8'h71, bs);
        u_tsc_host_model.cmd(a, d, `TSC_CMD_DATA_ONLY, bs);
        // A cancel issued while busy must be dropped, code stays full
        u_tsc_host_model.wr(`TSC_OFS_CMD, 8'h71);
        u_tsc_host_model.wr(`TSC_OFS_CMD, 8'h70);
        repeat (8) @(posedge ref_clk);
        look(a, q, te);
        chk(q.pointer, d);
        chk({4'h0, q.code}, {4'h0, `TSC_CODE_FULL});
        u_tsc_host_model.cmd(a, ~d, 8'h70, bs);
        look(a, q, te);
        chk(q.pointer, d);
        chk({4'h0, q.code}, {4'h0, `TSC_CODE_UNASSIGNED});
        chk({7'h0, q.switched}, 8'h00);
        $display("test cancel finished");
        // Output enables, kept clear of the post-reset sweep
        repeat (130) @(posedge ref_clk);
        a = 8'(rnd());
        for (int k = 0; k < 3; k++)
        begin
            d = 8'(rnd());
            u_tsc_host_model.cmd(a, {d[7:4], nib[k]}, `TSC_CMD_TRISTATE, bs);
            look(a, q, te);
            chk({4'h0, te}, {4'h0, nib[k]});
        end
        $display("test tristate finished");
        give_verdict();
    end
endmodule // testbench

bind tsc_cm_access tsc_cm_access_properties u_tsc_cm_access_properties (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .lookup_slot(lookup_slot),
    .lookup_conn(lookup_conn), .tx_slot(tx_slot), .tx_enable(tx_enable));
`default_nettype wire
